// ==== csor_pkg.sv ====
// Package for the core status and option register bank.
// Assumes one synchronous clock domain and a synchronous active-high reset.
package csor_pkg;

    // Avalon-MM byte addresses of the two registers.
    localparam logic [3:0] CSOR_STATUS_ADDR = 4'h0;
    localparam logic [3:0] CSOR_OPTION_ADDR = 4'h4;

    // Status register bit positions.
    localparam int CSOR_ST_IND_RSV = 7;
    localparam int CSOR_ST_HI_RSV = 6;
    localparam int CSOR_ST_BANK = 5;
    localparam int CSOR_ST_WDTO = 4;
    localparam int CSOR_ST_SLP = 3;
    localparam int CSOR_ST_ZERO = 2;
    localparam int CSOR_ST_NIB = 1;
    localparam int CSOR_ST_CARRY = 0;

    // Option register bit positions.
    localparam int CSOR_OP_PU_DIS = 7;
    localparam int CSOR_OP_IRQ_EDGE = 6;
    localparam int CSOR_OP_T0_SRC = 5;
    localparam int CSOR_OP_T0_EDGE = 4;
    localparam int CSOR_OP_PS_OWNER = 3;
    localparam int CSOR_OP_RATE_MSB = 2;

    // Values after reset; unknown flags are given zero.
    localparam logic [7:0] CSOR_STATUS_RST = 8'h18;
    localparam logic [7:0] CSOR_OPTION_RST = 8'hff;
    localparam logic [31:0] CSOR_READ_ZERO = 32'h0000_0000;

    // Number of pull-up pins served.
    localparam int CSOR_PU_PINS = 6;

    // Operations that the datapath presents for execution.
    typedef enum logic [3:0] {
        CSOR_OP_MOVE = 4'h0,
        CSOR_OP_ADD = 4'h1,
        CSOR_OP_SUB = 4'h2,
        CSOR_OP_AND = 4'h3,
        CSOR_OP_OR = 4'h4,
        CSOR_OP_XOR = 4'h5,
        CSOR_OP_CLR = 4'h6,
        CSOR_OP_RRF = 4'h7,
        CSOR_OP_RLF = 4'h8
    } csor_op_e;

    // Bus handshake states, one-hot.
    typedef enum logic [1:0] {
        CSOR_BUS_IDLE = 2'b01,
        CSOR_BUS_ACK = 2'b10
    } csor_bus_e;

endpackage

// ==== csor_regs.sv ====
// Status and option register bank with flag-producing ALU and Avalon slave.
// Assumes all inputs are synchronous to clk_sys_i; one op per cycle at most.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps

// Operation
// - Flag-affecting op into status ignores data for zero, nibble, carry.
// - Watchdog time-out and sleep-entered flags ignore software writes.
// - Clearing status zeroes top three bits, sets zero, keeps others.
// - Status bits 7 and 6 are reserved and drive nothing.
// - Status bit 5 selects data bank 1 or bank 0 for direct addressing.
// - Time-out flag set by reset, kick and sleep; cleared by time-out.
// - Sleep-entered flag set by reset and kick; cleared by sleep.
// - Zero flag set when an affecting op's result is zero.
// - Nibble flag takes carry out of bit 3 on add and subtract.
// - Carry flag takes carry out of bit 7 on add and subtract.
// - On subtract, carry and nibble flags are one when no borrow.
// - Subtract adds the two's complement of the second operand.
// - Rotates load carry with the bit shifted out of the source.
// - Option bit 7 high disables all pull-ups, else per-pin latches.
// - Option bit 6 picks rising (1) or falling (0) interrupt edge.
// - Option bit 5 picks external pin (1) or instruction clock (0).
// - Option bit 4 picks falling (1) or rising (0) external count edge.
// - Option bit 3 gives the prescaler to watchdog (1) or timer (0).
// - Rate bits give timer 2^(n+1) or watchdog 2^n division.
// - Timer counts undivided while the watchdog owns the prescaler.
module csor_regs
    import csor_pkg::*;
#(
    parameter int PU_PINS = CSOR_PU_PINS
)
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [3:0] av_address_i,
    input wire logic av_read_i,
    input wire logic av_write_i,
    input wire logic [31:0] av_writedata_i,
    input wire logic [3:0] av_byteenable_i,
    output logic [31:0] av_readdata_o,
    output logic av_waitrequest_o,
    input wire logic op_valid_i,
    input wire logic [3:0] op_code_i,
    input wire logic [7:0] op_a_i,
    input wire logic [7:0] op_b_i,
    input wire logic op_dest_status_i,
    output logic [7:0] op_result_o,
    output logic op_result_valid_o,
    input wire logic watchdog_kick_instr_i,
    input wire logic sleep_instr_i,
    input wire logic watchdog_timeout_i,
    input wire logic ext_irq_pin_i,
    input wire logic timer0_ext_clk_pin_i,
    input wire logic instr_cycle_tick_i,
    input wire logic [PU_PINS-1:0] pullup_latch_i,
    output logic [PU_PINS-1:0] pullup_en_o,
    output logic bank_sel_o,
    output logic ext_irq_event_o,
    output logic timer0_inc_o,
    output logic [3:0] timer0_div_log2_o,
    output logic [2:0] watchdog_div_log2_o
);

    csor_bus_e bus_state_r;
    logic [2:0] status_hi_r;
    logic [2:0] flags_r;
    logic to_r;
    logic pd_r;
    logic [7:0] option_r;
    logic [7:0] status_view;
    logic bus_accept;
    logic wr_status;
    logic wr_option;
    logic [7:0] wdata;
    csor_op_e op;
    logic [7:0] b_eff;
    logic cin;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] result;
    logic aff_z;
    logic aff_dc;
    logic aff_c;
    logic new_dc;
    logic new_c;
    logic [2:0] status_hi_nxt;
    logic [2:0] flags_nxt;
    logic irq_pin_r;
    logic t0_pin_r;

    assign status_view = {status_hi_r, to_r, pd_r, flags_r};
    assign op = csor_op_e'(op_code_i);

    // A request is taken at the edge where waitrequest is seen low.
    assign bus_accept = (bus_state_r == CSOR_BUS_ACK)
        && (av_read_i || av_write_i);
    assign wdata = av_writedata_i[7:0];
    assign wr_status = bus_accept && av_write_i && av_byteenable_i[0]
        && (av_address_i == CSOR_STATUS_ADDR);
    assign wr_option = bus_accept && av_write_i && av_byteenable_i[0]
        && (av_address_i == CSOR_OPTION_ADDR);

    // Every request waits exactly one cycle, then is answered.
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            bus_state_r <= CSOR_BUS_IDLE;
        end
        else
        begin
            unique case (bus_state_r)
                CSOR_BUS_IDLE:
                begin
                    if (av_read_i || av_write_i)
                    begin
                        bus_state_r <= CSOR_BUS_ACK;
                    end
                end
                CSOR_BUS_ACK:
                begin
                    bus_state_r <= CSOR_BUS_IDLE;
                end
                default:
                begin
                    bus_state_r <= CSOR_BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            av_waitrequest_o <= 1'b1;
            av_readdata_o <= CSOR_READ_ZERO;
        end
        else
        begin
            av_waitrequest_o <= !((bus_state_r == CSOR_BUS_IDLE)
                && (av_read_i || av_write_i));
            if ((bus_state_r == CSOR_BUS_IDLE) && av_read_i)
            begin
                unique case (av_address_i)
                    CSOR_STATUS_ADDR: av_readdata_o <= {24'h0, status_view};
                    CSOR_OPTION_ADDR: av_readdata_o <= {24'h0, option_r};
                    default: av_readdata_o <= CSOR_READ_ZERO;
                endcase
            end
        end
    end

    // Subtraction runs through the adder on the inverted operand plus one.
    always_comb
    begin
        b_eff = (op == CSOR_OP_SUB) ? ~op_b_i : op_b_i;
        cin = (op == CSOR_OP_SUB);
        sum = {1'b0, op_a_i} + {1'b0, b_eff} + {8'h00, cin};
        nib = {1'b0, op_a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
        result = op_a_i;
        aff_z = 1'b0;
        aff_dc = 1'b0;
        aff_c = 1'b0;
        new_dc = nib[4];
        new_c = sum[8];
        unique case (op)
            CSOR_OP_MOVE: result = op_a_i;
            CSOR_OP_ADD, CSOR_OP_SUB:
            begin
                result = sum[7:0];
                aff_z = 1'b1;
                aff_dc = 1'b1;
                aff_c = 1'b1;
            end
            CSOR_OP_AND:
            begin
                result = op_a_i & op_b_i;
                aff_z = 1'b1;
            end
            CSOR_OP_OR:
            begin
                result = op_a_i | op_b_i;
                aff_z = 1'b1;
            end
            CSOR_OP_XOR:
            begin
                result = op_a_i ^ op_b_i;
                aff_z = 1'b1;
            end
            CSOR_OP_CLR:
            begin
                result = 8'h00;
                aff_z = 1'b1;
            end
            CSOR_OP_RRF:
            begin
                result = {flags_r[CSOR_ST_CARRY], op_a_i[7:1]};
                new_c = op_a_i[0];
                aff_c = 1'b1;
            end
            CSOR_OP_RLF:
            begin
                result = {op_a_i[6:0], flags_r[CSOR_ST_CARRY]};
                new_c = op_a_i[7];
                aff_c = 1'b1;
            end
            default: result = op_a_i;
        endcase
    end

    // Bus write first, then the op overlays it in the same cycle.
    always_comb
    begin
        status_hi_nxt = status_hi_r;
        flags_nxt = flags_r;
        if (wr_status)
        begin
            status_hi_nxt = wdata[7:5];
            flags_nxt = wdata[2:0];
        end
        if (op_valid_i && op_dest_status_i)
        begin
            status_hi_nxt = result[7:5];
            if (!(aff_z || aff_dc || aff_c))
            begin
                flags_nxt = result[2:0];
            end
        end
        if (op_valid_i)
        begin
            // Written data never reaches a flag that the op drives.
            if (aff_z)
            begin
                flags_nxt[CSOR_ST_ZERO] = (result == 8'h00);
            end
            if (aff_dc)
            begin
                flags_nxt[CSOR_ST_NIB] = new_dc;
            end
            if (aff_c)
            begin
                flags_nxt[CSOR_ST_CARRY] = new_c;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            status_hi_r <= CSOR_STATUS_RST[7:5];
            flags_r <= CSOR_STATUS_RST[2:0];
        end
        else
        begin
            status_hi_r <= status_hi_nxt;
            flags_r <= flags_nxt;
        end
    end

    // Reset-cause flags follow only instructions and the watchdog.
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            to_r <= CSOR_STATUS_RST[CSOR_ST_WDTO];
            pd_r <= CSOR_STATUS_RST[CSOR_ST_SLP];
        end
        else
        begin
            if (watchdog_timeout_i)
            begin
                to_r <= 1'b0;
            end
            else if (watchdog_kick_instr_i || sleep_instr_i)
            begin
                to_r <= 1'b1;
            end
            if (sleep_instr_i)
            begin
                pd_r <= 1'b0;
            end
            else if (watchdog_kick_instr_i)
            begin
                pd_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            option_r <= CSOR_OPTION_RST;
        end
        else if (wr_option)
        begin
            option_r <= wdata;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            op_result_o <= 8'h00;
            op_result_valid_o <= 1'b0;
        end
        else
        begin
            op_result_o <= result;
            op_result_valid_o <= op_valid_i;
        end
    end

    // Pin edge detection for the interrupt and the external timer clock.
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            // Pins are taken as they stand so no false edge follows reset.
            irq_pin_r <= ext_irq_pin_i;
            t0_pin_r <= timer0_ext_clk_pin_i;
            ext_irq_event_o <= 1'b0;
            timer0_inc_o <= 1'b0;
        end
        else
        begin
            irq_pin_r <= ext_irq_pin_i;
            t0_pin_r <= timer0_ext_clk_pin_i;
            ext_irq_event_o <= option_r[CSOR_OP_IRQ_EDGE]
                ? (ext_irq_pin_i && !irq_pin_r)
                : (!ext_irq_pin_i && irq_pin_r);
            if (option_r[CSOR_OP_T0_SRC])
            begin
                timer0_inc_o <= option_r[CSOR_OP_T0_EDGE]
                    ? (!timer0_ext_clk_pin_i && t0_pin_r)
                    : (timer0_ext_clk_pin_i && !t0_pin_r);
            end
            else
            begin
                timer0_inc_o <= instr_cycle_tick_i;
            end
        end
    end

    // Division ratios are given as powers of two; zero means undivided.
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            timer0_div_log2_o <= 4'h0;
            watchdog_div_log2_o <= 3'h0;
            bank_sel_o <= CSOR_STATUS_RST[CSOR_ST_BANK];
        end
        else
        begin
            bank_sel_o <= status_hi_r[CSOR_ST_BANK - 5];
            if (option_r[CSOR_OP_PS_OWNER])
            begin
                timer0_div_log2_o <= 4'h0;
                watchdog_div_log2_o <= option_r[CSOR_OP_RATE_MSB:0];
            end
            else
            begin
                timer0_div_log2_o <= {1'b0, option_r[CSOR_OP_RATE_MSB:0]}
                    + 4'h1;
                watchdog_div_log2_o <= 3'h0;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PU_PINS; gi = gi + 1)
        begin : g_pu
            always_ff @(posedge clk_sys_i)
            begin
                if (srst_i)
                begin
                    pullup_en_o[gi] <= 1'b0;
                end
                else
                begin
                    pullup_en_o[gi] <= !option_r[CSOR_OP_PU_DIS]
                        && pullup_latch_i[gi];
                end
            end
        end
    endgenerate

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    sequence s_fire_arith;
        op_valid_i && (op == CSOR_OP_ADD || op == CSOR_OP_SUB);
    endsequence

    sequence s_bus_req;
        (av_read_i || av_write_i) && bus_state_r == CSOR_BUS_IDLE;
    endsequence

    a_bus_wait_one: assert property (s_bus_req |=> !av_waitrequest_o
        ##1 av_waitrequest_o)
        else $error("Bus answer not one cycle after request.");

    a_zero_flag_res: assert property (op_valid_i && aff_z |=>
        flags_r[CSOR_ST_ZERO] == (op_result_o == 8'h00))
        else $error("Zero flag does not match result.");

    a_sub_no_borrow: assert property (op_valid_i
        && op == CSOR_OP_SUB |=>
        flags_r[CSOR_ST_CARRY] == ($past(op_a_i) >= $past(op_b_i)))
        else $error("Subtract carry is not the no-borrow flag.");

    a_add_nib_carry: assert property (s_fire_arith
        ##0 op == CSOR_OP_ADD |=>
        flags_r[CSOR_ST_NIB] == ({1'b0, $past(op_a_i[3:0])}
        + {1'b0, $past(op_b_i[3:0])} > 5'h0f))
        else $error("Nibble carry wrong after add.");

    a_rot_carry_in: assert property (op_valid_i
        && op == CSOR_OP_RRF |=> flags_r[CSOR_ST_CARRY] == $past(op_a_i[0]))
        else $error("Rotate right did not load carry.");

    // A bus write to status in the same cycle may move the low flags.
    a_clr_status_dst: assert property (op_valid_i
        && op == CSOR_OP_CLR && op_dest_status_i && !wr_status
        |=> status_hi_r == 3'h0
        && flags_r[CSOR_ST_ZERO] && $stable(flags_r[1:0]))
        else $error("Clearing status gave a wrong pattern.");

    a_flags_hold: assert property (op_valid_i
        && op == CSOR_OP_MOVE && !op_dest_status_i && !wr_status
        |=> $stable(flags_r))
        else $error("Flags moved on a non-affecting op.");

    a_sleep_flags: assert property (sleep_instr_i
        && !watchdog_timeout_i |=> to_r && !pd_r)
        else $error("Sleep did not set time-out and clear power-down.");

    a_timeout_flag: assert property (watchdog_timeout_i
        |=> !to_r)
        else $error("Time-out flag not cleared by watchdog.");

    a_cause_readonly: assert property (!watchdog_timeout_i
        && !watchdog_kick_instr_i && !sleep_instr_i |=> $stable({to_r, pd_r}))
        else $error("Reset-cause flags changed without an event.");

    a_t0_undivided: assert property (option_r[CSOR_OP_PS_OWNER]
        |=> timer0_div_log2_o == 4'h0)
        else $error("Timer divided while watchdog owns prescaler.");

endmodule

// ==== csor_core_model.sv ====
// Behavioural model of the instruction datapath facing the register bank.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
module csor_core_model
(
    input wire logic clk_sys_i,
    output logic op_valid_o,
    output logic [3:0] op_code_o,
    output logic [7:0] op_a_o,
    output logic [7:0] op_b_o,
    output logic op_dest_status_o,
    output logic kick_o,
    output logic sleep_o,
    output logic timeout_o,
    output logic tick_o
);
    initial
    begin
        {op_valid_o, op_code_o, op_a_o, op_b_o, op_dest_status_o} = '0;
        {kick_o, sleep_o, timeout_o, tick_o} = 4'h0;
    end

    // Valid is left high so that back-to-back operations need no gap.
    task automatic exec(input logic [3:0] c, input logic [7:0] a,
                        input logic [7:0] b, input logic d);
        op_valid_o <= 1'b1;
        op_code_o <= c;
        op_a_o <= a;
        op_b_o <= b;
        op_dest_status_o <= d;
        @(posedge clk_sys_i);
    endtask

    // Operands no longer hold their last value once the op is over.
    task automatic idle();
        op_valid_o <= 1'b0;
        op_a_o <= ~op_a_o;
        op_b_o <= ~op_b_o;
        @(posedge clk_sys_i);
    endtask

    // One-cycle pulse of kick, sleep, time-out and tick, in that order.
    task automatic pulse(input logic [3:0] e);
        {kick_o, sleep_o, timeout_o, tick_o} <= e;
        @(posedge clk_sys_i);
        {kick_o, sleep_o, timeout_o, tick_o} <= 4'h0;
        @(posedge clk_sys_i);
    endtask
endmodule

// ==== csor_regs_test.sv ====
// Self-checking bench for the status and option register bank.
// Assumes the datapath model drives the op port and core events.
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
    fail_count++; $display("CHECK FAILED %s expected %h seen %h", \
    n, e, s); end end
module csor_regs_test
    import csor_pkg::*;
;
    logic clk_sys_i, srst_i, av_read_i, av_write_i, av_waitrequest_o;
    logic [3:0] av_address_i, av_byteenable_i, op_code, timer0_div_log2_o;
    logic [31:0] av_writedata_i, av_readdata_o, mon_e;
    logic op_valid, op_dest, kick, sleep, tmo, tick, op_result_valid_o;
    logic [7:0] op_a, op_b, op_result_o, st, v;
    logic ext_irq_pin_i, timer0_ext_clk_pin_i, bank_sel_o;
    logic ext_irq_event_o, timer0_inc_o;
    logic [5:0] pullup_latch_i, pullup_en_o;
    logic [2:0] watchdog_div_log2_o;
    logic [20:0] t;
    logic [23:0] evs = 24'h248ac6;
    logic [3:0] e;
    logic [20:0] tbl [5] = '{{4'h1, 8'h0f, 8'h01, 1'b0},
        {4'h2, 8'h5a, 8'h5a, 1'b0}, {4'h2, 8'h00, 8'h01, 1'b0},
        {4'h6, 8'hff, 8'h00, 1'b1}, {4'h1, 8'hf0, 8'h30, 1'b1}};
    logic [31:0] exp_q [$];
    int fail_count, comparisons, cycles, i;

    csor_regs dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .av_address_i(av_address_i), .av_read_i(av_read_i),
        .av_write_i(av_write_i), .av_writedata_i(av_writedata_i),
        .av_byteenable_i(av_byteenable_i), .av_readdata_o(av_readdata_o),
        .av_waitrequest_o(av_waitrequest_o), .op_valid_i(op_valid),
        .op_code_i(op_code), .op_a_i(op_a), .op_b_i(op_b),
        .op_dest_status_i(op_dest), .op_result_o(op_result_o),
        .op_result_valid_o(op_result_valid_o),
        .watchdog_kick_instr_i(kick), .sleep_instr_i(sleep),
        .watchdog_timeout_i(tmo), .ext_irq_pin_i(ext_irq_pin_i),
        .timer0_ext_clk_pin_i(timer0_ext_clk_pin_i),
        .instr_cycle_tick_i(tick), .pullup_latch_i(pullup_latch_i),
        .pullup_en_o(pullup_en_o), .bank_sel_o(bank_sel_o),
        .ext_irq_event_o(ext_irq_event_o), .timer0_inc_o(timer0_inc_o),
        .timer0_div_log2_o(timer0_div_log2_o),
        .watchdog_div_log2_o(watchdog_div_log2_o));

    csor_core_model core (.clk_sys_i(clk_sys_i), .op_valid_o(op_valid),
        .op_code_o(op_code), .op_a_o(op_a), .op_b_o(op_b),
        .op_dest_status_o(op_dest), .kick_o(kick), .sleep_o(sleep),
        .timeout_o(tmo), .tick_o(tick));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic wrap_up();
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    // Each result that appears takes the oldest expectation off the queue.
    always @(posedge clk_sys_i)
    begin
        if (op_result_valid_o === 1'b1)
        begin
            mon_e = exp_q.pop_front();
            if (mon_e !== 32'hffff_ffff)
                `CHK("op result", mon_e[7:0], op_result_o)
        end
        if (av_read_i === 1'b1 && av_waitrequest_o === 1'b0)
        begin
            mon_e = exp_q.pop_front();
            `CHK("read data", mon_e, av_readdata_o)
        end
    end

    task automatic bus(input logic wr, input logic [3:0] adr,
                       input logic [7:0] d, input logic [3:0] be);
        av_address_i <= adr;
        av_writedata_i <= {8'($urandom()), 16'h0, d};
        av_byteenable_i <= be;
        av_write_i <= wr;
        av_read_i <= !wr;
        @(posedge clk_sys_i);
        while (av_waitrequest_o !== 1'b0)
            @(posedge clk_sys_i);
        av_write_i <= 1'b0;
        av_read_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic rd(input logic [3:0] adr, input logic [7:0] x);
        exp_q.push_back({24'h0, x});
        bus(1'b0, adr, 8'h00, 4'hf);
    endtask

    task automatic wst(input logic [7:0] d);
        bus(1'b1, CSOR_STATUS_ADDR, d, 4'hf);
        st = {d[7:5], st[4:3], d[2:0]};
        rd(CSOR_STATUS_ADDR, st);
        `CHK("bank select", st[5], bank_sel_o)
    endtask

    task automatic edge_chk(input logic lvl, input logic xi,
                            input logic xt, input logic tk);
        logic [2:0] ni;
        logic [2:0] nt;
        ni = 3'h0;
        nt = 3'h0;
        ext_irq_pin_i <= lvl;
        timer0_ext_clk_pin_i <= lvl;
        if (tk)
            fork
                core.pulse(4'h1);
            join_none
        repeat (5)
        begin
            @(posedge clk_sys_i);
            ni += ext_irq_event_o;
            nt += timer0_inc_o;
        end
        `CHK("irq events", {2'b0, xi}, ni)
        `CHK("timer ticks", {2'b0, xt}, nt)
    endtask

    task automatic op(input logic [3:0] c, input logic [7:0] a,
                      input logic [7:0] b, input logic d);
        logic [8:0] s;
        logic [4:0] n;
        logic [7:0] r;
        s = {1'b0, a} + ((c == 4'h2) ? {1'b0, ~b} + 9'h1 : {1'b0, b});
        n = {1'b0, a[3:0]}
            + ((c == 4'h2) ? {1'b0, ~b[3:0]} + 5'h1 : {1'b0, b[3:0]});
        case (c)
            4'h1, 4'h2: r = s[7:0];
            4'h3: r = a & b;
            4'h4: r = a | b;
            4'h5: r = a ^ b;
            4'h6: r = 8'h00;
            4'h7: r = {st[0], a[7:1]};
            4'h8: r = {a[6:0], st[0]};
            default: r = a;
        endcase
        if (c == 4'h1 || c == 4'h2)
            st[1:0] = {n[4], s[8]};
        if (c >= 4'h1 && c <= 4'h6)
            st[2] = (r == 8'h00);
        if (c == 4'h7 || c == 4'h8)
            st[0] = (c == 4'h7) ? a[0] : a[7];
        if (d)
            st[7:5] = r[7:5];
        if (d && !(c inside {[4'h1:4'h8]}))
            st[2:0] = r[2:0];
        exp_q.push_back({24'h0, r});
        core.exec(c, a, b, d);
    endtask

    initial
    begin
        {av_read_i, av_write_i, av_address_i, av_writedata_i} = '0;
        {ext_irq_pin_i, timer0_ext_clk_pin_i, pullup_latch_i} = '0;
        av_byteenable_i = 4'hf;
        srst_i = 1'b1;
        st = 8'h18;
        void'($urandom(32'hbdc6a381));
        repeat (12) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i);
        rd(CSOR_STATUS_ADDR, 8'h18);
        rd(CSOR_OPTION_ADDR, 8'hff);
        for (i = 0; i < 8; i++)
        begin
            v = 8'($urandom());
            v[2:0] = i[2:0];
            pullup_latch_i <= 6'($urandom());
            bus(1'b1, CSOR_OPTION_ADDR, v, 4'hf);
            bus(1'b1, CSOR_OPTION_ADDR, ~v, 4'he);
            bus(1'b1, 4'hc, ~v, 4'hf);
            rd(4'hc, 8'h00);
            rd(CSOR_OPTION_ADDR, v);
            `CHK("pull-up", pullup_latch_i & {6{~v[7]}},
                pullup_en_o)
            `CHK("timer div", v[3] ? 4'h0 : {1'b0, v[2:0]} + 4'h1,
                timer0_div_log2_o)
            `CHK("wdt div", v[3] ? v[2:0] : 3'h0, watchdog_div_log2_o)
        end
        for (i = 0; i < 4; i++)
        begin
            bus(1'b1, CSOR_OPTION_ADDR, {1'b1, i[0], 1'b1, i[1], 4'h8}, 4'hf);
            edge_chk(1'b1, i[0], ~i[1], 1'b0);
            edge_chk(1'b0, ~i[0], i[1], 1'b0);
        end
        bus(1'b1, CSOR_OPTION_ADDR, 8'h08, 4'hf);
        edge_chk(1'b1, 1'b0, 1'b1, 1'b1);
        edge_chk(1'b0, 1'b1, 1'b0, 1'b0);
        wst(8'h00);
        wst(8'h25);
        wst(8'h05);
        wst(8'he7);
        for (i = 0; i < 6; i++)
        begin
            e = evs[23 - 4 * i -: 4];
            core.pulse(e);
            if (e[3])
                st[4:3] = 2'b11;
            if (e[2])
                st[4:3] = 2'b10;
            if (e[1])
                st[4] = 1'b0;
            rd(CSOR_STATUS_ADDR, st);
        end
        for (i = 0; i < 40; i++)
        begin
            t = tbl[i % 5];
            if (i < 5)
                op(t[20:17], t[16:9], t[8:1], t[0]);
            else
                repeat (3)
                    op(4'($urandom()), 8'($urandom()), 8'($urandom()),
                       $urandom_range(0, 5) == 0);
            core.idle();
            rd(CSOR_STATUS_ADDR, st);
            `CHK("bank follow", st[5], bank_sel_o)
        end
        wrap_up();
    end
endmodule
